// file: core/tmr_pkg.sv
// Constants and types shared by the target-mode status reporter.
// Assumes a single clock domain; byte lanes are packed little-endian into words.
package tmr_pkg;

   // ------------------------------------------------------------------
   // Command-status byte layout
   // ------------------------------------------------------------------
   localparam int CS_DIS_POS = 0;
   localparam int CS_CHK_POS = 1;
   localparam int CS_MSG_POS = 2;
   localparam int CS_CMD_POS = 3;
   localparam int CS_SEQ_LSB = 4;

   // ------------------------------------------------------------------
   // Flags byte layout
   // ------------------------------------------------------------------
   localparam int FL_TMS_POS = 0;
   localparam int FL_CSB_POS = 2;
   localparam int FL_RTY_POS = 5;
   localparam int FL_ERR_POS = 6;
   localparam int FL_CC_POS  = 7;

   // ------------------------------------------------------------------
   // Sequence codes
   // ------------------------------------------------------------------
   localparam logic [3:0] SEQ_NONE     = 4'h0;
   localparam logic [3:0] SEQ_FIRST    = 4'h1;
   localparam logic [3:0] SEQ_SECOND   = 4'h2;
   localparam logic [3:0] SEQ_QTAG     = 4'h3;
   localparam logic [3:0] SEQ_DATA     = 4'h4;
   localparam logic [3:0] SEQ_SELECT   = 4'h5;
   localparam logic [3:0] SEQ_IDENTIFY = 4'h6;
   localparam logic [3:0] SEQ_COMMAND  = 4'h7;
   localparam logic [3:0] SEQ_SYNC     = 4'h8;
   localparam logic [3:0] SEQ_WIDE     = 4'h9;
   localparam logic [3:0] SEQ_MAX      = SEQ_WIDE;

   // ------------------------------------------------------------------
   // Parameter block ID classes, counts and reset values
   // ------------------------------------------------------------------
   localparam logic [7:0] ID_SCSI_MAX   = 8'h0f;
   localparam logic [7:0] ID_BOARD      = 8'hff;
   localparam logic [3:0] CDB_FIRST_MAX = 4'h6;
   localparam logic [3:0] CDB_MAX       = 4'hc;
   localparam logic [2:0] LAST_WORD_ONE = 3'h3;
   localparam logic [2:0] LAST_WORD_TWO = 3'h7;
   localparam logic [7:0] RST_BYTE      = 8'h00;
   localparam logic [31:0] RST_WORD     = 32'h0000_0000;

   typedef enum logic [1:0] {ST_IDLE, ST_COLLECT, ST_WRITE} tmr_state_t;

endpackage

// file: core/tmr_status_reporter.sv
// Target-mode status reporter: gathers per-command events and writes the status block(s).
// Assumes the target engine pulses events synchronously to mclk_i and a memory writer
// accepts words with sb_ready_i.
`timescale 1ns/100ps
`default_nettype none

module tmr_status_reporter (
   // Clock, reset and enable
   input  wire logic        mclk_i,
   input  wire logic        reset_n_i,
   input  wire logic        clk_en_i,
   // Command framing
   input  wire logic        cmd_start_i,
   input  wire logic [31:0] cmd_id_i,
   input  wire logic        cmd_target_resp_i,
   input  wire logic        cmd_done_i,
   // Bus events
   input  wire logic        disc_evt_i,
   input  wire logic        chk_evt_i,
   input  wire logic        atn_msg_valid_i,
   input  wire logic [7:0]  atn_msg_byte_i,
   input  wire logic [3:0]  phase_code_i,
   input  wire logic        err_evt_i,
   input  wire logic [7:0]  err_code_i,
   input  wire logic        err_fatal_i,
   input  wire logic        cdb_byte_valid_i,
   input  wire logic [7:0]  cdb_byte_i,
   // Status block writer
   output logic             sb_valid_o,
   output logic [2:0]       sb_word_idx_o,
   output logic [31:0]      sb_data_o,
   input  wire logic        sb_ready_i,
   output logic             busy_o,
   // Parameter block classifier
   input  wire logic [7:0]  pb_id_i,
   output logic             pb_pass_through_o,
   output logic             pb_board_control_o
);

   // ------------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------------
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   tmr_pkg::tmr_state_t state;
   tmr_pkg::tmr_state_t next_state;
   logic [31:0] cmd_id;
   logic [31:0] next_cmd_id;
   logic        tm_resp;
   logic        next_tm_resp;
   logic        dis;
   logic        next_dis;
   logic        chk;
   logic        next_chk;
   logic        msg;
   logic        next_msg;
   logic [7:0]  msg_byte;
   logic [7:0]  next_msg_byte;
   logic [3:0]  seq;
   logic [3:0]  next_seq;
   logic        err_flag;
   logic        next_err_flag;
   logic [7:0]  err_code;
   logic [7:0]  next_err_code;
   logic [7:0]  cdb      [0:11];
   logic [7:0]  next_cdb [0:11];
   logic [3:0]  cdb_len;
   logic [3:0]  next_cdb_len;
   logic [2:0]  widx;
   logic [2:0]  next_widx;
   logic        sb_valid;
   logic        next_sb_valid;
   logic [31:0] sb_data;
   logic [31:0] next_sb_data;
   logic        pb_pt;
   logic        next_pb_pt;
   logic        pb_bc;
   logic        next_pb_bc;
   logic        ev_ok;
   logic [2:0]  last_word;

   // Keeps reported codes inside the defined range.
   function automatic logic [3:0] legal_seq(input logic [3:0] p);
      return (p > tmr_pkg::SEQ_MAX) ? tmr_pkg::SEQ_NONE : p;
   endfunction

   // Builds one word of the first or second status block.
   function automatic logic [31:0] block_word(input logic [2:0] idx);
      logic [7:0] cs;
      logic [7:0] fl;
      cs = {seq, (cdb_len != 4'h0), msg, chk, dis};
      fl = tmr_pkg::RST_BYTE;
      fl[tmr_pkg::FL_CC_POS]  = 1'b1;
      fl[tmr_pkg::FL_ERR_POS] = err_flag;
      fl[tmr_pkg::FL_TMS_POS] = tm_resp;
      fl[tmr_pkg::FL_CSB_POS] = idx[2];
      unique case (idx)
         3'h0, 3'h4: block_word = cmd_id;
         3'h1:       block_word = {fl, err_code, tmr_pkg::RST_BYTE, cs};
         3'h2:       block_word = {cdb[1], cdb[0], 4'h0, cdb_len, msg_byte};
         3'h3:       block_word = {cdb[5], cdb[4], cdb[3], cdb[2]};
         3'h5:       block_word = {fl, err_code, tmr_pkg::RST_BYTE, tmr_pkg::RST_BYTE};
         3'h6:       block_word = {cdb[9], cdb[8], cdb[7], cdb[6]};
         default:    block_word = {tmr_pkg::RST_BYTE, tmr_pkg::RST_BYTE, cdb[11], cdb[10]};
      endcase
   endfunction

   // ------------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------------
   always_comb begin
      next_state    = state;
      next_cmd_id   = cmd_id;
      next_tm_resp  = tm_resp;
      next_dis      = dis;
      next_chk      = chk;
      next_msg      = msg;
      next_msg_byte = msg_byte;
      next_seq      = seq;
      next_err_flag = err_flag;
      next_err_code = err_code;
      next_cdb      = cdb;
      next_cdb_len  = cdb_len;
      next_widx     = widx;
      next_sb_valid = sb_valid;
      next_sb_data  = sb_data;
      last_word     = (cdb_len > tmr_pkg::CDB_FIRST_MAX) ? tmr_pkg::LAST_WORD_TWO
                                                         : tmr_pkg::LAST_WORD_ONE;
      ev_ok         = (state == tmr_pkg::ST_COLLECT)
                      || (cmd_start_i && state != tmr_pkg::ST_WRITE);
      next_pb_pt    = (pb_id_i <= tmr_pkg::ID_SCSI_MAX);
      next_pb_bc    = (pb_id_i == tmr_pkg::ID_BOARD);

      // A start outside ST_WRITE clears the record; events in the same cycle still land.
      if (cmd_start_i && state != tmr_pkg::ST_WRITE) begin
         next_state    = tmr_pkg::ST_COLLECT;
         next_cmd_id   = cmd_id_i;
         next_tm_resp  = cmd_target_resp_i;
         next_dis      = 1'b0;
         next_chk      = 1'b0;
         next_msg      = 1'b0;
         next_msg_byte = tmr_pkg::RST_BYTE;
         next_seq      = tmr_pkg::SEQ_NONE;
         next_err_flag = 1'b0;
         next_err_code = tmr_pkg::RST_BYTE;
         next_cdb_len  = 4'h0;
      end
      if (ev_ok) begin
         if (disc_evt_i) begin
            next_dis = 1'b1;
         end
         if (chk_evt_i) begin
            next_chk = 1'b1;
         end
         if (err_evt_i) begin
            next_err_flag = 1'b1;
            next_err_code = err_code_i;
            if (err_fatal_i) begin
               next_seq = legal_seq(phase_code_i);
            end
         end
         if (atn_msg_valid_i) begin
            next_msg      = 1'b1;
            next_msg_byte = atn_msg_byte_i;
            next_seq      = legal_seq(phase_code_i);
         end
         if (cdb_byte_valid_i && next_cdb_len < tmr_pkg::CDB_MAX) begin
            next_cdb[next_cdb_len] = cdb_byte_i;
            next_cdb_len = next_cdb_len + 4'h1;
         end
      end

      unique case (state)
         tmr_pkg::ST_IDLE: begin
         end
         tmr_pkg::ST_COLLECT: begin
            if (cmd_done_i && !cmd_start_i) begin
               next_state    = tmr_pkg::ST_WRITE;
               next_widx     = 3'h0;
               next_sb_valid = 1'b1;
               next_sb_data  = cmd_id;
            end
         end
         tmr_pkg::ST_WRITE: begin
            if (sb_ready_i) begin
               if (widx == last_word) begin
                  next_state    = tmr_pkg::ST_IDLE;
                  next_sb_valid = 1'b0;
               end else begin
                  next_widx    = widx + 3'h1;
                  next_sb_data = block_word(widx + 3'h1);
               end
            end
         end
         default: begin
            next_state    = tmr_pkg::ST_IDLE;
            next_sb_valid = 1'b0;
         end
      endcase
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         state    <= tmr_pkg::ST_IDLE;
         cmd_id   <= tmr_pkg::RST_WORD;
         tm_resp  <= 1'b0;
         dis      <= 1'b0;
         chk      <= 1'b0;
         msg      <= 1'b0;
         msg_byte <= tmr_pkg::RST_BYTE;
         seq      <= tmr_pkg::SEQ_NONE;
         err_flag <= 1'b0;
         err_code <= tmr_pkg::RST_BYTE;
         for (int i = 0; i < 12; i++) begin
            cdb[i] <= tmr_pkg::RST_BYTE;
         end
         cdb_len  <= 4'h0;
         widx     <= 3'h0;
         sb_valid <= 1'b0;
         sb_data  <= tmr_pkg::RST_WORD;
         pb_pt    <= 1'b0;
         pb_bc    <= 1'b0;
      end else if (clk_en_i) begin
         state    <= next_state;
         cmd_id   <= next_cmd_id;
         tm_resp  <= next_tm_resp;
         dis      <= next_dis;
         chk      <= next_chk;
         msg      <= next_msg;
         msg_byte <= next_msg_byte;
         seq      <= next_seq;
         err_flag <= next_err_flag;
         err_code <= next_err_code;
         cdb      <= next_cdb;
         cdb_len  <= next_cdb_len;
         widx     <= next_widx;
         sb_valid <= next_sb_valid;
         sb_data  <= next_sb_data;
         pb_pt    <= next_pb_pt;
         pb_bc    <= next_pb_bc;
      end
   end

   assign sb_valid_o         = sb_valid;
   assign sb_word_idx_o      = widx;
   assign sb_data_o          = sb_data;
   assign busy_o             = (state != tmr_pkg::ST_IDLE);
   assign pb_pass_through_o  = pb_pt;
   assign pb_board_control_o = pb_bc;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n);

   logic collect_en;
   assign collect_en = clk_en_i && (state == tmr_pkg::ST_COLLECT) && !cmd_start_i;

   a_dis_flag_set: assert property (collect_en && disc_evt_i |=> dis)
      else $error("disconnect flag not set");
   a_chk_flag_set: assert property (collect_en && chk_evt_i |=> chk)
      else $error("check condition flag not set");
   a_msg_byte_capture: assert property (collect_en && atn_msg_valid_i
      |=> msg && msg_byte == $past(atn_msg_byte_i))
      else $error("message byte not captured");
   a_seq_from_phase: assert property (collect_en && atn_msg_valid_i
      && phase_code_i <= tmr_pkg::SEQ_MAX |=> seq == $past(phase_code_i))
      else $error("sequence code does not follow phase");
   a_seq_code_legal: assert property (seq <= tmr_pkg::SEQ_MAX)
      else $error("reserved sequence code held");
   a_cmd_status_word: assert property (sb_valid && widx == 3'h1
      |-> sb_data[tmr_pkg::CS_CMD_POS] == (cdb_len != 4'h0)
          && sb_data[7:4] == seq)
      else $error("command status byte wrong");
   a_tms_flag_out: assert property (sb_valid && widx == 3'h1
      |-> sb_data[24 + tmr_pkg::FL_TMS_POS] == tm_resp)
      else $error("target status flag wrong");
   a_second_block_only: assert property (sb_valid && cdb_len <= tmr_pkg::CDB_FIRST_MAX
      |-> !widx[2])
      else $error("second block without long command");
   a_cdb_len_count: assert property (collect_en && cdb_byte_valid_i && cdb_len < tmr_pkg::CDB_MAX
      |=> cdb_len == $past(cdb_len) + 4'h1)
      else $error("command byte count wrong");
   a_err_code_store: assert property (collect_en && err_evt_i
      |=> err_code == $past(err_code_i) && err_flag)
      else $error("error code not stored");
   a_pass_through_id: assert property (clk_en_i && pb_id_i <= tmr_pkg::ID_SCSI_MAX
      |=> pb_pass_through_o && !pb_board_control_o)
      else $error("pass-through id misclassified");
   a_board_ctrl_id: assert property (clk_en_i && pb_id_i == tmr_pkg::ID_BOARD
      |=> pb_board_control_o && !pb_pass_through_o)
      else $error("board-control id misclassified");

   c_short_block: cover property (sb_valid && widx == tmr_pkg::LAST_WORD_ONE && sb_ready_i
      && cdb_len == tmr_pkg::CDB_FIRST_MAX);
   c_long_block: cover property (sb_valid && widx == tmr_pkg::LAST_WORD_TWO && sb_ready_i);
   c_msg_reported: cover property (sb_valid && widx == 3'h1 && msg);

endmodule

`default_nettype wire

// file: bench/tmr_sb_sink.sv
// Far-side model of the status block writer: takes words and keeps the block image.
// Assumes the bench pulses clear_i before each command and may ask for stalls.
`timescale 1ns/100ps
`default_nettype none

module tmr_sb_sink (
   // Clock and control
   input  wire logic         mclk_i,
   input  wire logic         clear_i,
   input  wire logic         stall_i,
   // Status block words
   input  wire logic         sb_valid_i,
   input  wire logic [2:0]   sb_word_idx_i,
   input  wire logic [31:0]  sb_data_i,
   output logic              sb_ready_o,
   // Captured block image
   output logic [255:0]      blk_o,
   output logic [3:0]        n_o,
   output logic              ord_err_o
);
   // ---------------------------------------------------------------
   // Word capture
   // ---------------------------------------------------------------
   // A stall makes ready drop every other cycle, whether or not a word is offered.
   always @(posedge mclk_i) begin
      sb_ready_o <= stall_i ? ~sb_ready_o : 1'b1;
      if (clear_i) begin
         blk_o     <= '1;
         n_o       <= 4'h0;
         ord_err_o <= 1'b0;
      end else if (sb_valid_i && sb_ready_o) begin
         blk_o[{sb_word_idx_i, 5'h00} +: 32] <= sb_data_i;
         n_o                                 <= n_o + 4'h1;
         if ({1'b0, sb_word_idx_i} !== n_o) begin
            ord_err_o <= 1'b1;
         end
      end
   end
endmodule

`default_nettype wire

// file: bench/test_tmr_status_reporter.sv
// Self-checking bench for the target-mode status reporter.
// Assumes tmr_sb_sink stands on the far side of the status block writer.
`timescale 1ns/100ps
`default_nettype none

`define SAME(what, exp, got) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("BAD %s exp %h got %h", what, exp, got); end end

module test_tmr_status_reporter;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   localparam logic [7:0] ERR_CODE = 8'h3c;
   logic          mclk_i, reset_n_i, clk_en_i, cmd_start_i, cmd_target_resp_i, cmd_done_i;
   logic          disc_evt_i, chk_evt_i, atn_msg_valid_i, err_evt_i, err_fatal_i;
   logic          cdb_byte_valid_i, clr, stall;
   logic [31:0]   cmd_id_i;
   logic [7:0]    atn_msg_byte_i, err_code_i, cdb_byte_i, pb_id_i;
   logic [3:0]    phase_code_i, n_words;
   wire logic     sb_valid_o, sb_ready_i, busy_o, pb_pass_through_o, pb_board_control_o;
   wire logic     ord_err;
   wire logic [2:0]   sb_word_idx_o;
   wire logic [31:0]  sb_data_o;
   wire logic [255:0] blk;
   int            n_mismatch = 0;
   int            compares = 0;
   int            p;
   logic [7:0]    ids [6] = '{8'h00, 8'h07, 8'h0f, 8'h10, 8'hfe, 8'hff};

   tmr_status_reporter u_tmr_status_reporter (
      .mclk_i(mclk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
      .cmd_start_i(cmd_start_i), .cmd_id_i(cmd_id_i), .cmd_target_resp_i(cmd_target_resp_i),
      .cmd_done_i(cmd_done_i), .disc_evt_i(disc_evt_i), .chk_evt_i(chk_evt_i),
      .atn_msg_valid_i(atn_msg_valid_i), .atn_msg_byte_i(atn_msg_byte_i),
      .phase_code_i(phase_code_i), .err_evt_i(err_evt_i), .err_code_i(err_code_i),
      .err_fatal_i(err_fatal_i), .cdb_byte_valid_i(cdb_byte_valid_i), .cdb_byte_i(cdb_byte_i),
      .sb_valid_o(sb_valid_o), .sb_word_idx_o(sb_word_idx_o), .sb_data_o(sb_data_o),
      .sb_ready_i(sb_ready_i), .busy_o(busy_o), .pb_id_i(pb_id_i),
      .pb_pass_through_o(pb_pass_through_o), .pb_board_control_o(pb_board_control_o));

   tmr_sb_sink u_tmr_sb_sink (
      .mclk_i(mclk_i), .clear_i(clr), .stall_i(stall), .sb_valid_i(sb_valid_o),
      .sb_word_idx_i(sb_word_idx_o), .sb_data_i(sb_data_o), .sb_ready_o(sb_ready_i),
      .blk_o(blk), .n_o(n_words), .ord_err_o(ord_err));

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic end_test(input string name);
      $display("test %s done, mismatches so far %0d", name, n_mismatch);
   endtask

   task automatic classify(input logic [7:0] id);
      @(posedge mclk_i);
      pb_id_i <= id;
      @(posedge mclk_i);
      #1;
      `SAME("pass through", id <= 8'h0f, pb_pass_through_o)
      `SAME("board control", id == 8'hff, pb_board_control_o)
   endtask

   // One command: start, events (ev = err, msg, chk, disc), command bytes, done, block check.
   task automatic run_cmd(input logic [31:0] id, input logic tr, input logic [3:0] ev,
                          input logic [3:0] ph, input int nb, input logic st);
      int          i;
      int          nbs;
      logic [3:0]  seq;
      logic [7:0]  fl;
      logic [7:0]  eb;
      nbs = (nb > 12) ? 12 : nb;
      seq = ((ev[2] | ev[3]) && ph <= 4'h9) ? ph : 4'h0;
      fl  = {1'b1, ev[3], 5'h00, tr};
      eb  = ev[3] ? ERR_CODE : 8'h00;
      @(posedge mclk_i);
      cmd_start_i       <= 1'b1;
      cmd_id_i          <= id;
      cmd_target_resp_i <= tr;
      clr               <= 1'b1;
      stall             <= st;
      @(posedge mclk_i);
      cmd_start_i     <= 1'b0;
      clr             <= 1'b0;
      disc_evt_i      <= ev[0];
      chk_evt_i       <= ev[1];
      atn_msg_valid_i <= ev[2];
      atn_msg_byte_i  <= {4'h8, ph};
      err_evt_i       <= ev[3];
      err_fatal_i     <= ev[3];
      err_code_i      <= ERR_CODE;
      phase_code_i    <= ph;
      @(posedge mclk_i);
      {disc_evt_i, chk_evt_i, atn_msg_valid_i, err_evt_i, err_fatal_i} <= 5'h00;
      for (i = 0; i < nb; i++) begin
         cdb_byte_valid_i <= 1'b1;
         cdb_byte_i       <= 8'h10 + 8'(i);
         @(posedge mclk_i);
      end
      cdb_byte_valid_i <= 1'b0;
      cmd_done_i       <= 1'b1;
      @(posedge mclk_i);
      cmd_done_i <= 1'b0;
      #1;
      for (i = 0; i < 200 && busy_o !== 1'b0; i++) begin
         @(posedge mclk_i);
         #1;
      end
      `SAME("busy", 1'b0, busy_o)
      `SAME("word order", 1'b0, ord_err)
      `SAME("words", (nbs > 6) ? 4'h8 : 4'h4, n_words)
      `SAME("id", id, blk[31:0])
      `SAME("cmd status", {seq, nbs != 0, ev[2:0]}, blk[39:32])
      `SAME("error", eb, blk[55:48])
      `SAME("flags", fl, blk[63:56])
      `SAME("length", 8'(nbs), blk[79:72])
      if (ev[2]) `SAME("message", {4'h8, ph}, blk[71:64])
      for (i = 0; i < nbs; i++) begin
         `SAME("cdb", 8'h10 + 8'(i), blk[((i < 6) ? 80 + 8*i : 144 + 8*i) +: 8])
      end
      if (nbs > 6) begin
         `SAME("id 2", id, blk[159:128])
         `SAME("error 2", eb, blk[183:176])
         `SAME("flags 2", fl | 8'h04, blk[191:184])
      end
   endtask

   // ---------------------------------------------------------------
   // Clock, watchdog and test sequence
   // ---------------------------------------------------------------
   initial begin
      mclk_i = 1'b0;
      forever #10 mclk_i = ~mclk_i;
   end

   initial begin
      repeat (20000) @(posedge mclk_i);
      n_mismatch++;
      $display("watchdog expired before the tests ended");
      print_verdict();
   end

   initial begin
      reset_n_i = 1'b0;
      clk_en_i  = 1'b1;
      {cmd_start_i, cmd_target_resp_i, cmd_done_i, disc_evt_i, chk_evt_i} = 5'h00;
      {atn_msg_valid_i, err_evt_i, err_fatal_i, cdb_byte_valid_i, clr, stall} = 6'h00;
      {cmd_id_i, atn_msg_byte_i, err_code_i, cdb_byte_i, pb_id_i, phase_code_i} = '0;
      repeat (6) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      #1;
      `SAME("valid in reset", 1'b0, sb_valid_o)
      `SAME("busy in reset", 1'b0, busy_o)
      repeat (4) @(posedge mclk_i);
      end_test("reset");
      foreach (ids[k]) classify(ids[k]);
      end_test("classifier");
      @(posedge mclk_i);
      clk_en_i <= 1'b0;
      pb_id_i  <= 8'h00;
      repeat (2) @(posedge mclk_i);
      #1;
      `SAME("frozen board control", 1'b1, pb_board_control_o)
      `SAME("frozen pass through", 1'b0, pb_pass_through_o)
      @(posedge mclk_i);
      clk_en_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      #1;
      `SAME("thawed pass through", 1'b1, pb_pass_through_o)
      `SAME("thawed board control", 1'b0, pb_board_control_o)
      end_test("clock enable");
      run_cmd(32'h0000_0001, 1'b1, 4'h0, 4'h0, 0, 1'b0);
      end_test("quiet command");
      for (p = 0; p < 12; p++) begin
         run_cmd(32'h100 + p, 1'b1, 4'h4, 4'(p), 6, p[0]);
      end
      end_test("sequence codes");
      run_cmd(32'hcafe_0002, 1'b1, 4'hb, 4'h7, 13, 1'b1);
      end_test("long command");
      run_cmd(32'h0000_0003, 1'b0, 4'h8, 4'hc, 10, 1'b0);
      end_test("other command");
      print_verdict();
   end
endmodule

`default_nettype wire
